// *** logic/mtog_guard.sv ***
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module mtog_guard
#(
    parameter int SAMPLE_CYC = mtog_pkg::SAMPLE_CYCLES
)
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Avalon-MM slave
    input  wire logic [5:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    // Sensor side
    input  wire logic [15:0] sensor_analog_input_a,
    input  wire logic [15:0] sensor_analog_input_b,
    input  wire logic        thermistor_digital_input,
    output logic [13:0]      excitation_ua,
    // Motor measurement
    input  wire logic [15:0] motor_current,
    input  wire logic [15:0] motor_speed,
    // Retained storage
    input  wire logic        nv_valid,
    input  wire logic [23:0] nv_temp,
    input  wire logic [27:0] nv_level,
    output logic             nv_store,
    output logic [23:0]      nv_temp_out,
    output logic [27:0]      nv_level_out,
    // Protection outputs
    output logic             temp_warning,
    output logic             temp_fault,
    output logic             overload_warning,
    output logic             overload_fault,
    output logic             thermistor_trip
);
    import mtog_pkg::*;

    // ************************************
    // Conversion helpers
    // ************************************
    function automatic logic [13:0] exc_of(input logic [2:0] t);
        if (t == MTOG_PT100) exc_of = EXC_PT100_UA;
        else if (t == MTOG_PT1000) exc_of = EXC_PT1000_UA;
        else if (t == MTOG_NI1000) exc_of = EXC_NI1000_UA;
        else if (t == MTOG_SI_A) exc_of = EXC_SI_A_UA;
        else if (t == MTOG_SI_B) exc_of = EXC_SI_B_UA;
        else exc_of = 14'h0;
    endfunction : exc_of

    // Temperature in C from mV; ref point (mohm, C) and slope in mohm/C
    function automatic logic signed [15:0] to_celsius(input logic [2:0] t,
                                                      input logic [15:0] mv,
                                                      input logic [1:0] n);
        logic signed [47:0] mohm;
        logic signed [47:0] rref;
        logic signed [47:0] slope;
        logic signed [47:0] tref;
        logic signed [47:0] res;
        mohm  = 48'sd0;
        rref  = 48'sd0;
        slope = 48'sd1;
        tref  = 48'sd0;
        if (exc_of(t) != 14'h0)
            mohm = $signed({32'h0, mv}) * 48'sd1000000 / $signed({34'h0, exc_of(t)});
        if (t == MTOG_PT100)
        begin
            rref  = 48'sd100000 * $signed({46'h0, n});
            slope = 48'(PT100_SLOPE_MOH) * $signed({46'h0, n});
        end
        else if (t == MTOG_PT1000)
        begin
            rref  = 48'sd1000000 * $signed({46'h0, n});
            slope = 48'(PT1000_SLOPE_MOH) * $signed({46'h0, n});
        end
        else if (t == MTOG_NI1000)
        begin
            rref  = 48'(NI_R100_OHM * 1000);
            slope = 48'(NI_SLOPE_MOH);
            tref  = 48'sd100;
        end
        else if (t == MTOG_SI_A)
        begin
            rref  = 48'(SI_A_R100_OHM * 1000);
            slope = 48'(SI_A_SLOPE_MOH);
            tref  = 48'sd100;
        end
        else if (t == MTOG_SI_B)
        begin
            rref  = 48'(SI_B_R100_OHM * 1000);
            slope = 48'(SI_B_SLOPE_MOH);
            tref  = 48'sd100;
        end
        res = tref + (mohm - rref) / slope;
        to_celsius = res[15:0];
    endfunction : to_celsius

    // ************************************
    // Registers
    // ************************************
    logic [31:0] ctrl;
    logic [15:0] ambient;
    logic [23:0] curve;
    logic [9:0]  olcfg;
    logic [31:0] limits;
    logic [15:0] nomcur;
    logic        ptc_latch;
    logic [2:0]  din_sync;
    logic [27:0] ol_level;
    logic [23:0] est_temp;
    logic signed [15:0] meas_temp;
    logic [31:0] tick_cnt;
    logic        started;

    wire  [2:0]  sens_type  = ctrl[2:0];
    wire  [1:0]  sens_count = (ctrl[5:4] == 2'h0) ? 2'h1 : ctrl[5:4];
    wire         relay_no   = ctrl[8];
    wire         use_input_b = ctrl[9];
    wire         nema       = ctrl[12];
    wire  [1:0]  temp_react = ctrl[17:16];
    wire  [1:0]  ol_action  = olcfg[9:8];
    wire  [7:0]  ol_class   = olcfg[7:0];

    // ************************************
    // Bus decode
    // ************************************
    wire         bus_take = (read | write) & ~waitrequest;
    wire         wr_en    = write & ~waitrequest;
    wire         wr_ctrl  = wr_en && address == A_CTRL;
    wire         wr_stat  = wr_en && address == A_STATUS;
    wire  [31:0] status_word = {24'h0, thermistor_trip, ptc_latch, overload_fault,
                                overload_warning, temp_fault, temp_warning, started,
                                nv_valid};
    wire  [7:0]  ol_pct;
    wire  [15:0] trip_level;
    logic [31:0] rd_mux;
    always_comb
    begin
        if (address == A_CTRL) rd_mux = ctrl;
        else if (address == A_AMBIENT) rd_mux = {16'h0, ambient};
        else if (address == A_CURVE) rd_mux = {8'h0, curve};
        else if (address == A_OLCFG) rd_mux = {22'h0, olcfg};
        else if (address == A_LIMITS) rd_mux = limits;
        else if (address == A_NOMCUR) rd_mux = {16'h0, nomcur};
        else if (address == A_STATUS) rd_mux = status_word;
        else if (address == A_ESTTEMP) rd_mux = {{16{est_temp[23]}}, est_temp[23:8]};
        else if (address == A_MEASTMP) rd_mux = {{16{meas_temp[15]}}, meas_temp};
        else if (address == A_OLLEVEL) rd_mux = {24'h0, ol_pct};
        else if (address == A_TRIPLVL) rd_mux = {16'h0, trip_level};
        else rd_mux = 32'h0;
    end

    // One wait state per access; unmapped reads return zero, writes dropped
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0;
        end
        else
        begin
            waitrequest <= ~((read | write) & waitrequest);
            readdata    <= rd_mux;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl    <= RST_CTRL;
            ambient <= RST_AMBIENT;
            curve   <= RST_CURVE;
            olcfg   <= RST_OLCFG;
            limits  <= RST_LIMITS;
            nomcur  <= RST_NOMCUR;
        end
        else if (wr_en)
        begin
            if (address == A_CTRL) ctrl <= writedata;
            else if (address == A_AMBIENT) ambient <= writedata[15:0];
            else if (address == A_CURVE) curve <= writedata[23:0];
            else if (address == A_OLCFG) olcfg <= writedata[9:0];
            else if (address == A_LIMITS) limits <= writedata;
            else if (address == A_NOMCUR) nomcur <= writedata[15:0];
        end
    end

    // ************************************
    // Sample tick
    // ************************************
    wire tick = (tick_cnt == 32'(SAMPLE_CYC - 1));
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n) tick_cnt <= 32'h0;
        else tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
    end

    // ************************************
    // Load curve and trip level
    // ************************************
    // Percent of nominal: zero-speed load rising linearly to curve level at break
    wire  [7:0]  lc_level = curve[7:0];
    wire  [7:0]  lc_zero  = curve[15:8];
    wire  [7:0]  lc_break = curve[23:16];
    wire  [31:0] lc_span  = 32'(lc_level) - 32'(lc_zero);
    wire  [31:0] lc_ramp  = 32'(lc_zero) + 32'(lc_span * 32'(motor_speed)
                            / ((lc_break == 8'h0) ? 32'h1 : 32'(lc_break)));
    wire  [31:0] lc_pct   = (motor_speed >= 16'(lc_break)) ? 32'(lc_level) : lc_ramp;
    wire  [31:0] trip_raw = 32'(nomcur) * lc_pct / 32'd100;
    assign trip_level = (trip_raw[15:0] == 16'h0) ? 16'h1 : trip_raw[15:0];

    // ************************************
    // Overload accumulator
    // ************************************
    wire  [31:0] ratio_q8  = (32'(motor_current) << 8) / 32'(trip_level);
    wire  [47:0] rsq_full  = 48'(ratio_q8) * 48'(ratio_q8);
    wire  [31:0] ratio_sq  = (rsq_full[47:40] != 8'h0) ? 32'hffff_ffff : rsq_full[39:8];
    wire  [31:0] mult_sq   = nema ? 32'(NEMA_MULT_SQ_X100) : 32'(IEC_MULT_SQ_X100);
    wire  [31:0] rate_div  = mult_sq * ((ol_class == 8'h0) ? 32'h1 : 32'(ol_class));
    wire  [47:0] ol_inc    = 48'(ratio_sq) * 48'd102400 / 48'(rate_div);
    wire  [27:0] ol_decay  = ol_level >> OL_DECAY_SHIFT;
    wire  [47:0] ol_sum    = 48'(ol_level) + ol_inc;
    wire  [27:0] next_ol   = (ratio_sq < 32'd256) ? ol_level - ol_decay
                           : (ol_sum > 48'(OL_MAX)) ? OL_MAX : ol_sum[27:0];
    wire  [27:0] ol_shift  = ol_level >> OL_PCT_SHIFT;
    assign ol_pct = (ol_shift > 28'd255) ? 8'hff : ol_shift[7:0];

    // ************************************
    // Thermal estimate (Q8 degrees)
    // ************************************
    wire  [7:0]  rise_c    = ctrl[31:24];
    wire  signed [31:0] est_target = $signed({{8{ambient[15]}}, ambient, 8'h0}) + $signed(32'(ratio_sq)
                                     * 32'(rise_c));
    wire  signed [31:0] est_diff   = est_target - $signed({{8{est_temp[23]}}, est_temp});
    wire  signed [31:0] est_step   = est_diff >>> EST_TAU_SHIFT;
    wire  signed [31:0] est_sum    = $signed({{8{est_temp[23]}}, est_temp}) + est_step;
    wire  [23:0] next_est = (est_sum > 32'sh007f_ffff) ? 24'h7f_ffff : est_sum[23:0];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            started  <= 1'b0;
            est_temp <= 24'h0;
            ol_level <= 28'h0;
        end
        else if (!started)
        begin
            started  <= 1'b1;
            est_temp <= nv_valid ? nv_temp : {ambient[15:0], 8'h0};
            ol_level <= nv_valid ? nv_level : 28'h0;
        end
        else if (tick)
        begin
            est_temp <= next_est;
            ol_level <= next_ol;
        end
    end

    // Retained copy pushed every sample
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nv_store     <= 1'b0;
            nv_temp_out  <= 24'h0;
            nv_level_out <= 28'h0;
        end
        else
        begin
            nv_store     <= started & tick;
            nv_temp_out  <= est_temp;
            nv_level_out <= ol_level;
        end
    end

    // ************************************
    // Measured temperature
    // ************************************
    wire [15:0] mv_in = use_input_b ? sensor_analog_input_b : sensor_analog_input_a;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            excitation_ua <= 14'h0;
            meas_temp     <= 16'sh0;
        end
        else
        begin
            excitation_ua <= exc_of(sens_type);
            if (tick) meas_temp <= to_celsius(sens_type, mv_in, sens_count);
        end
    end

    // ************************************
    // Digital sensor input
    // ************************************
    // Two stages guard against the asynchronous pin; third is the edge history
    wire din_fall  = din_sync[2] & ~din_sync[1];
    wire ptc_event = (sens_type == MTOG_PTC) && din_fall;
    wire relay_hot = (sens_type == MTOG_RELAY) && (din_sync[1] == relay_no);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            din_sync  <= 3'b111;
            ptc_latch <= 1'b0;
        end
        else
        begin
            din_sync  <= {din_sync[1:0], thermistor_digital_input};
            // Set beats write-one-to-clear in the same cycle
            ptc_latch <= ptc_event | (ptc_latch & ~(wr_stat & writedata[6]));
        end
    end

    // ************************************
    // Supervision and overload outputs
    // ************************************
    wire signed [15:0] lim_warn = limits[15:0];
    wire signed [15:0] lim_flt  = limits[31:16];
    wire meas_type   = sens_type != MTOG_NONE && sens_type != MTOG_PTC && sens_type != MTOG_RELAY;
    wire over_warn   = meas_type && (meas_temp >= lim_warn);
    wire over_flt    = meas_type && (meas_temp >= lim_flt);
    wire next_twarn  = (temp_react != 2'h0) && over_warn;
    wire next_tflt   = (temp_react == REACT_FAULT) && over_flt;
    wire next_olwarn = (ol_action != 2'h0) && (ol_pct >= OL_WARN_PCT);
    wire next_olflt  = (ol_action == REACT_FAULT) && (ol_pct >= OL_TRIP_PCT);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            temp_warning     <= 1'b0;
            temp_fault       <= 1'b0;
            overload_warning <= 1'b0;
            overload_fault   <= 1'b0;
            thermistor_trip  <= 1'b0;
        end
        else
        begin
            temp_warning     <= next_twarn;
            temp_fault       <= next_tflt | (temp_fault & ~(wr_stat & writedata[3]));
            overload_warning <= next_olwarn;
            overload_fault   <= next_olflt | (overload_fault & ~(wr_stat & writedata[5]));
            thermistor_trip  <= relay_hot | ptc_latch;
        end
    end

    // ************************************
    // Checks
    // ************************************
    sequence s_access;
        (read | write) & waitrequest;
    endsequence
    sequence s_answer;
        !waitrequest ##1 waitrequest;
    endsequence
    a_bus_one_wait: assert property (@(posedge clk) disable iff (!rst_n)
        s_access |=> s_answer)
        else $error("Bus answer not after one wait state");
    a_first_load: assert property (@(posedge clk) disable iff (!rst_n)
        (!started && !nv_valid) |=> est_temp == {$past(ambient), 8'h0})
        else $error("Estimate not seeded from ambient");
    a_nv_resume: assert property (@(posedge clk) disable iff (!rst_n)
        (!started && nv_valid) |=> ol_level == $past(nv_level))
        else $error("Overload state not resumed");
    a_nv_store: assert property (@(posedge clk) disable iff (!rst_n)
        (started && tick) |=> nv_store ##1 !nv_store || $past(tick))
        else $error("Retained store not pulsed");
    a_ptc_edge: assert property (@(posedge clk) disable iff (!rst_n)
        ptc_event |=> ptc_latch ##1 thermistor_trip)
        else $error("PTC fall not flagged");
    a_exc_pt100: assert property (@(posedge clk) disable iff (!rst_n)
        (sens_type == MTOG_PT100) [*2] |-> excitation_ua == 14'd9100)
        else $error("Pt100 excitation wrong");
    a_exc_pt1000: assert property (@(posedge clk) disable iff (!rst_n)
        (sens_type == MTOG_PT1000) [*2] |-> excitation_ua == 14'd100)
        else $error("Pt1000 excitation wrong");
    a_exc_ni1000: assert property (@(posedge clk) disable iff (!rst_n)
        (sens_type == MTOG_NI1000) [*2] |-> excitation_ua == 14'd9100)
        else $error("Ni1000 excitation wrong");
    a_exc_si_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sens_type == MTOG_SI_A) [*2] |-> excitation_ua == 14'd2000)
        else $error("Silicon A excitation wrong");
    a_exc_si_b: assert property (@(posedge clk) disable iff (!rst_n)
        (sens_type == MTOG_SI_B) [*2] |-> excitation_ua == 14'd1000)
        else $error("Silicon B excitation wrong");
    a_ol_warn: assert property (@(posedge clk) disable iff (!rst_n)
        (ol_action != 2'h0 && ol_pct >= 8'd88) |=> overload_warning)
        else $error("Overload warning missing at 88 percent");
    a_ol_trip: assert property (@(posedge clk) disable iff (!rst_n)
        overload_fault |-> $past(ol_action == REACT_FAULT && ol_pct >= 8'd100)
                           || $past(overload_fault))
        else $error("Overload fault without cause");
    a_ol_saturate: assert property (@(posedge clk) disable iff (!rst_n)
        ol_level <= OL_MAX)
        else $error("Overload accumulator wrapped");
    a_ol_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (started && !tick) |=> $stable(ol_level))
        else $error("Accumulator moved between samples");
    a_relay_pol: assert property (@(posedge clk) disable iff (!rst_n)
        relay_hot |=> thermistor_trip)
        else $error("Relay trip missing");
    a_temp_fault: assert property (@(posedge clk) disable iff (!rst_n)
        (temp_react == REACT_FAULT && over_flt) |=> temp_fault)
        else $error("Temperature fault missing");
endmodule : mtog_guard
`default_nettype wire

// *** logic/mtog_pkg.sv ***
package mtog_pkg;
    // ************************************
    // Register map (byte addresses)
    // ************************************
    localparam logic [5:0] A_CTRL    = 6'h00;
    localparam logic [5:0] A_AMBIENT = 6'h04;
    localparam logic [5:0] A_CURVE   = 6'h08;
    localparam logic [5:0] A_OLCFG   = 6'h0c;
    localparam logic [5:0] A_LIMITS  = 6'h10;
    localparam logic [5:0] A_NOMCUR  = 6'h14;
    localparam logic [5:0] A_STATUS  = 6'h18;
    localparam logic [5:0] A_ESTTEMP = 6'h1c;
    localparam logic [5:0] A_MEASTMP = 6'h20;
    localparam logic [5:0] A_OLLEVEL = 6'h24;
    localparam logic [5:0] A_TRIPLVL = 6'h28;
    // ************************************
    // Reset values
    // ************************************
    localparam logic [31:0] RST_CTRL    = 32'h0000_0001;
    localparam logic [15:0] RST_AMBIENT = 16'h001e;
    localparam logic [23:0] RST_CURVE   = 24'h32_46_64;
    localparam logic [9:0]  RST_OLCFG   = 10'h214;
    localparam logic [31:0] RST_LIMITS  = 32'h0082_006e;
    localparam logic [15:0] RST_NOMCUR  = 16'h0064;
    // ************************************
    // Sensor types and reactions
    // ************************************
    typedef enum logic [2:0] {
        MTOG_NONE = 3'b000, MTOG_PT100 = 3'b001, MTOG_PT1000 = 3'b010,
        MTOG_NI1000 = 3'b011, MTOG_SI_A = 3'b100, MTOG_SI_B = 3'b101,
        MTOG_PTC = 3'b110, MTOG_RELAY = 3'b111
    } mtog_sensor_e;
    localparam logic [1:0] REACT_WARN  = 2'h1;
    localparam logic [1:0] REACT_FAULT = 2'h2;
    // ************************************
    // Excitation (uA) and conversion
    // ************************************
    localparam logic [13:0] EXC_PT100_UA  = 14'd9100;
    localparam logic [13:0] EXC_PT1000_UA = 14'd100;
    localparam logic [13:0] EXC_NI1000_UA = 14'd9100;
    localparam logic [13:0] EXC_SI_A_UA   = 14'd2000;
    localparam logic [13:0] EXC_SI_B_UA   = 14'd1000;
    localparam int NI_R100_OHM  = 1618;
    localparam int NI_PPM       = 6180;
    localparam int NI_SLOPE_MOH = NI_R100_OHM * NI_PPM / 1000;
    localparam int PT100_SLOPE_MOH  = 385;
    localparam int PT1000_SLOPE_MOH = 3850;
    // Silicon sensor curves: plain defaults, tune per part
    localparam int SI_A_R100_OHM  = 1000;
    localparam int SI_A_SLOPE_MOH = 7600;
    localparam int SI_B_R100_OHM  = 2000;
    localparam int SI_B_SLOPE_MOH = 15800;
    // ************************************
    // Overload and thermal model
    // ************************************
    localparam int SAMPLE_MS      = 10;
    localparam int CLK_KHZ        = 50000;
    localparam int SAMPLE_CYCLES  = SAMPLE_MS * CLK_KHZ;
    localparam int SAMPLES_PER_S  = 1000 / SAMPLE_MS;
    localparam int IEC_MULT_SQ_X100  = 5184;
    localparam int NEMA_MULT_SQ_X100 = 3600;
    localparam logic [27:0] OL_FULL = 28'd26214400;
    localparam logic [27:0] OL_MAX  = 28'd52428800;
    localparam int OL_PCT_SHIFT   = 18;
    localparam logic [7:0] OL_WARN_PCT = 8'd88;
    localparam logic [7:0] OL_TRIP_PCT = 8'd100;
    localparam int OL_DECAY_SHIFT = 10;
    localparam int EST_TAU_SHIFT  = 12;
endpackage : mtog_pkg

// *** tb/mtog_sensor_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// Motor side: one Ni1000 winding sensor, a contact, current and speed
module mtog_sensor_model
(
    // Bench demands
    input  wire logic [15:0] temp_c,
    input  wire logic        contact,
    input  wire logic [15:0] amps,
    // Device pins
    input  wire logic [13:0] excitation_ua,
    output logic [15:0]      sensor_analog_input_a,
    output logic [15:0]      sensor_analog_input_b,
    output logic             thermistor_digital_input,
    output logic [15:0]      motor_current,
    output logic [15:0]      motor_speed
);
    import mtog_pkg::*;
    int r_moh;
    // Voltage follows the current actually driven, so a wrong excitation shows
    always_comb r_moh = NI_R100_OHM * 1000 + NI_SLOPE_MOH * (int'(temp_c) - 100);
    assign sensor_analog_input_a = 16'((longint'(excitation_ua) * r_moh) / 1000000);
    // Unselected input carries an unrelated level
    assign sensor_analog_input_b = ~sensor_analog_input_a;
    assign thermistor_digital_input = contact;
    assign motor_current = amps;
    // Above break point; one motor, class chosen by the bench
    assign motor_speed = 16'h0064;
endmodule : mtog_sensor_model
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import mtog_pkg::*;
    logic clk = 0, rst_n = 0, read = 0, write = 0, contact = 1, nv_valid = 0;
    logic [5:0] address = '0;
    logic [31:0] writedata = '0, q, readdata;
    logic [15:0] temp_c = 16'h0064, amps = '0, ain_a, ain_b, cur, spd;
    logic [23:0] nv_temp = '0;
    logic [27:0] nv_level = '0;
    logic [13:0] exc;
    logic waitrequest, pin, t_w, t_f, o_w, o_f, th_trip, st;
    logic [23:0] nvt;
    logic [27:0] nvl;
    int num_errors = 0, check_count = 0, n, t;
    logic [5:0] ra[8] = '{A_CTRL, A_AMBIENT, A_CURVE, A_OLCFG, A_LIMITS, A_NOMCUR,
                          A_ESTTEMP, 6'h3c};
    logic [31:0] rv[8] = '{32'h1, 32'h1e, 32'h324664, 32'h214, 32'h82006e, 32'h64, 32'h1e, 32'h0};
    logic [13:0] ex[6] = '{14'h0, EXC_PT100_UA, EXC_PT1000_UA, EXC_NI1000_UA,
                           EXC_SI_A_UA, EXC_SI_B_UA};
    mtog_sensor_model pm (.temp_c(temp_c), .contact(contact), .amps(amps), .excitation_ua(exc),
        .sensor_analog_input_a(ain_a), .sensor_analog_input_b(ain_b),
        .thermistor_digital_input(pin), .motor_current(cur), .motor_speed(spd));
    mtog_guard #(.SAMPLE_CYC(16)) dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .sensor_analog_input_a(ain_a), .sensor_analog_input_b(ain_b),
        .thermistor_digital_input(pin), .excitation_ua(exc), .motor_current(cur),
        .motor_speed(spd), .nv_valid(nv_valid), .nv_temp(nv_temp), .nv_level(nv_level),
        .nv_store(st), .nv_temp_out(nvt), .nv_level_out(nvl), .temp_warning(t_w), .temp_fault(t_f),
        .overload_warning(o_w), .overload_fault(o_f), .thermistor_trip(th_trip));
    initial forever #10 clk = ~clk;
    task results;
        if (num_errors == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Request held until waitrequest is sampled low
    task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a; read <= !wr; write <= wr; writedata <= d;
        n = 0;
        do @(posedge clk); while (waitrequest !== 1'b0 && ++n < 50);
        if (n >= 50) begin num_errors++; results; end
        q = readdata;
        read <= 0; write <= 0;
    endtask : bus
    // Waits for fault 0 temp, 1 overload warning, 2 overload fault, 3 store pulse
    task till(input int sel, input int lim);
        n = 0;
        while ((sel == 0 ? t_f : sel == 1 ? o_w : sel == 2 ? o_f : st) !== 1'b1 && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= lim) begin num_errors++; results; end
    endtask : till
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1;
        foreach (ra[i]) begin bus(0, ra[i], 0); chk("reset reg", q, rv[i]); end
        for (int i = 1; i < 6; i++) begin bus(1, A_CTRL, i); repeat (3) @(posedge clk);
            chk("excitation", exc, ex[i]); end
        contact <= 0; bus(1, A_CTRL, 32'h107); repeat (6) @(posedge clk);
        chk("relay idle", th_trip, 0);
        contact <= 1; repeat (6) @(posedge clk);
        chk("relay open", th_trip, 1);
        bus(1, A_CTRL, 32'h7); contact <= 0; repeat (6) @(posedge clk);
        chk("relay nc open", th_trip, 1);
        contact <= 1; repeat (6) @(posedge clk);
        chk("relay nc closed", th_trip, 0);
        bus(1, A_CTRL, 32'h6); bus(1, A_STATUS, 32'h68); contact <= 0; repeat (6) @(posedge clk);
        bus(0, A_STATUS, 0); chk("ptc latch", q[6], 1);
        bus(1, A_LIMITS, 32'h5f_005a); bus(1, A_CTRL, 32'h2_0003); till(0, 400);
        chk("temp warn", t_w, 1);
        bus(0, A_MEASTMP, 0); chk("meas temp", q >= 99 && q <= 101, 1);
        bus(1, A_OLCFG, 32'h20a); bus(0, A_TRIPLVL, 0); chk("trip level", q, 32'h64);
        amps <= 16'd720; till(1, 30000); t = n;
        chk("warn point", t > 12600 && t < 15500 && o_f === 1'b0, 1);
        till(2, 30000); chk("trip time", t + n > 14400 && t + n < 17600, 1);
        bus(0, A_OLLEVEL, 0); chk("level", q >= 100 && q <= 101, 1);
        till(3, 40);
        chk("store temp", nvt[23:8], 32'd30);
        chk("store level", nvl >= OL_FULL, 1);
        rst_n <= 0; nv_valid <= 1; nv_temp <= 24'h3200; nv_level <= OL_MAX;
        repeat (20) @(posedge clk);
        rst_n <= 1;
        bus(0, A_OLLEVEL, 0); chk("kept level", q, 32'd200);
        bus(0, A_ESTTEMP, 0); chk("kept temp", q, 32'd50);
        chk("kept fault", o_f, 1);
        results;
    end
endmodule : tb_top
`default_nettype wire
